// ==== bench/host_model.sv ====
/*
  Host-side model of the serial register master: pointer loads, register
  writes and register reads, each as a one-cycle strobe.
  Assumes one caller at a time and a free-running ref_clk.
*/
module host_model (
  input  wire logic        ref_clk,
  output logic             ptr_wr,
  output logic [1:0]       ptr_val,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle strobes from time zero
  initial begin
    ptr_wr    = 1'b0;
    ptr_val   = 2'h0;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer first, strobe a cycle later, so the new pointer is in force
  task automatic load_ptr(input logic [1:0] p);
    @(negedge ref_clk);
    ptr_wr  = 1'b1;
    ptr_val = p;
    @(negedge ref_clk);
    ptr_wr  = 1'b0;
    ptr_val = ~p; // released lines show junk, not the last value
  endtask : load_ptr

  // word write at pointer p
  task automatic write_reg(input logic [1:0] p, input logic [15:0] d);
    load_ptr(p);
    reg_wr    = 1'b1;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : write_reg

  // answer must come at the very next edge; taken half a cycle later,
  // where it is settled and before the following edge drops the valid pulse
  task automatic read_reg(input logic [1:0] p, output logic [15:0] d, output bit ok);
    load_ptr(p);
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    ok = (rd_valid_q === 1'b1);
    d  = rd_data_q;
  endtask : read_reg
endmodule : host_model

// ==== bench/tb_adc_result_and_config_regs.sv ====
/*
  Self-checking bench for the result and configuration registers.
  Assumes the host model drives the register strobes and this module
  plays the analog front end; CLK_HZ is cut down to keep runs short.
*/
module tb_adc_result_and_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_regs_pkg::*;

  localparam int DIV = 8600; // reduced clock rate: 860 per second is 10 cycles
  logic        ref_clk, reset_n, ptr_wr, reg_wr, reg_rd, rd_valid_q, beyond_threshold;
  logic        alert_response, converting_q, conv_done_q, alert_o_q, alert_oe_q;
  logic [1:0]  ptr_val;
  logic [2:0]  input_pair_sel_q, gain_range_sel_q;
  logic [15:0] reg_wdata, rd_data_q, sample_in;
  int          errors, checked, k;
  int          sps[8] = '{8, 16, 32, 64, 128, 250, 475, 860};

  adc_result_and_config_regs #(.CLK_HZ(DIV), .CNT_W(24)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ptr_wr(ptr_wr), .ptr_val(ptr_val),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .sample_in(sample_in), .beyond_threshold(beyond_threshold),
    .alert_response(alert_response), .input_pair_sel_q(input_pair_sel_q),
    .gain_range_sel_q(gain_range_sel_q), .converting_q(converting_q),
    .conv_done_q(conv_done_q), .alert_o_q(alert_o_q), .alert_oe_q(alert_oe_q));

  host_model u_host (
    .ref_clk(ref_clk), .ptr_wr(ptr_wr), .ptr_val(ptr_val), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  // 40 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic rd(input logic [1:0] p, input logic [15:0] exp, input string what);
    logic [15:0] d;
    bit          ok;
    u_host.read_reg(p, d, ok);
    chk1({what, " valid"}, 1'b1, ok);
    chk16(what, exp, d);
  endtask : rd

  function automatic logic [15:0] cfg(input logic os, input logic [2:0] rate,
                                      input logic mode, input logic [4:0] cmp);
    return {os, 3'h0, 3'h2, mode, rate, cmp};
  endfunction : cfg

  // bounded wait; k counts edges from the write edge to the done pulse
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (conv_done_q !== 1'b1 && n < 1200);
    if (conv_done_q !== 1'b1) begin
      errors++;
      $display("Error conv_done expected 1 seen %b", conv_done_q);
      stop_test();
    end
  endtask : wait_done

  task automatic run_conv(input logic [15:0] c, output int n);
    u_host.write_reg(2'h1, c);
    wait_done(n);
  endtask : run_conv

  // pin is judged two edges after the done pulse
  task automatic conv_alert(input logic [15:0] c, input logic b, input logic pin);
    int n;
    @(negedge ref_clk);
    beyond_threshold = b;
    run_conv(c, n);
    repeat (2) @(posedge ref_clk);
    #1;
    chk1("alert pin", pin, alert_o_q);
    chk1("alert enable", 1'b1, alert_oe_q);
  endtask : conv_alert

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(PTR_RESULT, 16'h0000, "result at reset");
    rd(PTR_CONFIG, 16'h8583, "config at reset");
    rd(2'h2, 16'h0000, "unmapped read");
    chk16("pair", 16'h0000, {13'h0, input_pair_sel_q});
    chk16("range", 16'h0002, {13'h0, gain_range_sel_q});
    chk1("alert enable", 1'b0, alert_oe_q);
  endtask : t_reset

  task automatic t_read_only();
    u_host.write_reg(PTR_RESULT, 16'h5A5A);
    rd(PTR_RESULT, 16'h0000, "result after write");
  endtask : t_read_only

  // every pair and range code, with no start requested
  task automatic t_fields();
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {1'b0, 3'(i), 3'(7 - i), 1'b1, 3'h4, 5'h03};
      u_host.write_reg(PTR_CONFIG, w);
      chk16("pair", {13'h0, 3'(i)}, {13'h0, input_pair_sel_q});
      chk16("range", {13'h0, 3'(7 - i)}, {13'h0, gain_range_sel_q});
      chk1("no start", 1'b0, converting_q);
      rd(PTR_CONFIG, {1'b1, w[14:0]}, "config readback");
    end
  endtask : t_fields

  // each rate code sets the length of a single-shot conversion
  task automatic t_rates();
    for (int r = 0; r < 8; r++) begin
      sample_in = 16'h8000 + 16'(r);
      run_conv(cfg(1'b1, 3'(r), 1'b1, 5'h03), k);
      chk16("cycles", 16'(DIV / sps[r]), 16'(k));
      chk1("idle after", 1'b0, converting_q);
      rd(PTR_RESULT, sample_in, "result");
      rd(PTR_CONFIG, cfg(1'b1, 3'(r), 1'b1, 5'h03), "status after");
    end
  endtask : t_rates

  // status while busy, and a second start that must be ignored
  task automatic t_busy();
    sample_in = 16'h1234;
    u_host.write_reg(PTR_CONFIG, 16'h8503);
    rd(PTR_CONFIG, 16'h0503, "status busy");
    u_host.write_reg(PTR_CONFIG, 16'hD503);
    chk16("pair busy", 16'h0005, {13'h0, input_pair_sel_q});
    wait_done(k);
    chk1("idle after", 1'b0, converting_q);
    rd(PTR_RESULT, 16'h1234, "result busy");
    repeat (20) @(posedge ref_clk);
    #1;
    chk1("no restart", 1'b0, converting_q);
  endtask : t_busy

  task automatic t_cont();
    @(negedge ref_clk);
    sample_in = 16'h7FFF;
    run_conv(cfg(1'b0, 3'h7, 1'b0, 5'h03), k);
    chk16("first", 16'(DIV / 860), 16'(k));
    @(negedge ref_clk);
    sample_in = 16'h0101;
    wait_done(k);
    chk16("reload", 16'(DIV / 860), 16'(k));
    chk1("still busy", 1'b1, converting_q);
    rd(PTR_RESULT, 16'h0101, "result cont");
    u_host.write_reg(PTR_CONFIG, cfg(1'b0, 3'h7, 1'b1, 5'h03));
    wait_done(k);
    chk1("stopped", 1'b0, converting_q);
  endtask : t_cont

  task automatic t_alert();
    for (int q = 0; q < 3; q++) begin
      u_host.write_reg(PTR_CONFIG, cfg(1'b0, 3'h7, 1'b1, 5'h0B));
      repeat (2) @(posedge ref_clk);
      #1;
      chk1("floated", 1'b0, alert_oe_q);
      for (int j = 1; j < (1 << q); j++) conv_alert(cfg(1'b1, 3'h7, 1'b1, {3'h2, 2'(q)}), 1'b1, 1'b0);
      conv_alert(cfg(1'b1, 3'h7, 1'b1, {3'h2, 2'(q)}), 1'b1, 1'b1);
      conv_alert(cfg(1'b1, 3'h7, 1'b1, {3'h2, 2'(q)}), 1'b0, 1'b0);
    end
    u_host.write_reg(PTR_CONFIG, cfg(1'b0, 3'h7, 1'b1, 5'h07));
    conv_alert(cfg(1'b1, 3'h7, 1'b1, 5'h04), 1'b1, 1'b0);
    conv_alert(cfg(1'b1, 3'h7, 1'b1, 5'h04), 1'b0, 1'b0);
    rd(PTR_RESULT, sample_in, "result latch");
    repeat (3) @(posedge ref_clk);
    #1;
    chk1("cleared by read", 1'b1, alert_o_q);
    conv_alert(cfg(1'b1, 3'h7, 1'b1, 5'h04), 1'b1, 1'b0);
    @(negedge ref_clk);
    alert_response = 1'b1;
    @(negedge ref_clk);
    alert_response = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk1("cleared by response", 1'b1, alert_o_q);
  endtask : t_alert

  // reset in the middle of continuous conversion
  task automatic t_reset_mid();
    u_host.write_reg(PTR_CONFIG, cfg(1'b0, 3'h7, 1'b0, 5'h03));
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk1("busy after reset", 1'b0, converting_q);
    t_reset();
  endtask : t_reset_mid

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n          = 1'b0;
    sample_in        = 16'h0000;
    beyond_threshold = 1'b0;
    alert_response   = 1'b0;
    errors           = 0;
    checked          = 0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset();
    t_read_only();
    t_fields();
    t_rates();
    t_busy();
    t_cont();
    t_alert();
    t_reset_mid();
    stop_test();
  end
endmodule : tb_adc_result_and_config_regs

// ==== core/adc_regs_pkg.sv ====
/*
  Shared constants for the converter result and configuration registers:
  pointer codes, field positions, reset values and the sample-rate table.
  Assumes a single ref_clk domain.
*/
package adc_regs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register pointer codes
  localparam logic [1:0]  PTR_RESULT    = 2'h0;
  localparam logic [1:0]  PTR_CONFIG    = 2'h1;

  // reset values
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [15:0] CONFIG_RESET  = 16'h8583;
  localparam logic [1:0]  PTR_RESET     = 2'h0;

  // configuration field positions
  localparam int          STATUS_BIT    = 15;
  localparam int          PAIR_LSB      = 12;
  localparam int          RANGE_LSB     = 9;
  localparam int          MODE_BIT      = 8;
  localparam int          RATE_LSB      = 5;
  localparam int          WINMODE_BIT   = 4;
  localparam int          POL_BIT       = 3;
  localparam int          LATCH_BIT     = 2;
  localparam int          QUEUE_LSB     = 0;

  // comparator queue code that switches the comparator off
  localparam logic [1:0]  QUEUE_OFF     = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // sample rates in samples per second, one per rate code
  localparam int          SPS_0         = 8;
  localparam int          SPS_1         = 16;
  localparam int          SPS_2         = 32;
  localparam int          SPS_3         = 64;
  localparam int          SPS_4         = 128;
  localparam int          SPS_5         = 250;
  localparam int          SPS_6         = 475;
  localparam int          SPS_7         = 860;

  // reference clock rate and period
  localparam int          REF_CLK_HZ    = 25_000_000;
  localparam int          REF_PERIOD_NS = 40;

endpackage : adc_regs_pkg

// ==== core/adc_result_and_config_regs.sv ====
/*
  Result and configuration registers of a 16-bit delta-sigma converter,
  reached through a two-bit register pointer from a serial slave engine.
  Assumes the slave engine delivers pointer writes, register writes and
  register reads as one-cycle strobes on ref_clk, and that the analog
  front end presents a signed sample and a threshold flag at all times.
*/
// Function
// - each finished conversion replaces the signed 16-bit result register
// - result reads zero from power-up until the first conversion finishes
// - pointer 0 selects result, pointer 1 selects configuration
// - configuration register is read/write and resets to 8583h
// - writing 1 to bit 15, or 0 to bit 8, while idle starts conversion, else ignored
// - bit 15 reads 0 while converting and 1 while idle
// - bits 14:12 select the input pair, reset 000
// - bits 11:9 select the full-scale range, reset 010
// - bit 8 chooses continuous (0) or single-shot/power-down (1)
// - bits 7:5 select the sample rate, reset 128 per second
// - queue 11 floats the alert pin; else assert after 1, 2 or 4 hits
// - latched alert stays asserted until result read or alert response
// - polarity bit 0 makes alert active low, 1 active high
module adc_result_and_config_regs #(
  parameter int CLK_HZ = adc_regs_pkg::REF_CLK_HZ,
  parameter int CNT_W  = 24
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // strobes from the serial slave engine
  input  wire logic        ptr_wr,
  input  wire logic [1:0]  ptr_val,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] rd_data_q,
  output logic             rd_valid_q,
  // analog front end
  input  wire logic [15:0] sample_in,
  input  wire logic        beyond_threshold,
  input  wire logic        alert_response,
  output logic      [2:0]  input_pair_sel_q,
  output logic      [2:0]  gain_range_sel_q,
  output logic             converting_q,
  output logic             conv_done_q,
  // alert/ready pin, driven while alert_oe_q is high
  output logic             alert_o_q,
  output logic             alert_oe_q
);
  import adc_regs_pkg::*;

  if (CNT_W < 2 || CNT_W > 31) begin : g_check
    $error("adc_result_and_config_regs: CNT_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]       ptr_q, ptr_d;
  logic [15:0]      result_q, result_d;
  logic [14:0]      cfg_q, cfg_d;
  logic             busy_q, busy_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             done_q, done_d;
  logic [15:0]      rd_data_d;
  logic             rd_valid_d;
  logic             alert_o_d, alert_oe_d;

  logic             wr_cfg, rd_result, start, finish, restart;
  logic [2:0]       rate_now;
  logic [CNT_W-1:0] period;
  logic             alert_lvl;
  logic             seen_q;

  // live view of the configuration word with the status bit folded in
  function automatic logic [15:0] cfg_view(input logic [14:0] c, input logic b);
    cfg_view = {~b, c};
  endfunction : cfg_view

  ////////////////////////////////////////////////////////////////////////
  // access decode; a write in the pointer-write cycle uses the old pointer
  always_comb begin
    wr_cfg    = reg_wr && (ptr_q == PTR_CONFIG);
    rd_result = reg_rd && (ptr_q == PTR_RESULT);
    finish    = busy_q && (cnt_q == '0);
    // idle: a 1 in bit 15 or a switch to continuous starts work
    start     = wr_cfg && !busy_q &&
                (reg_wdata[STATUS_BIT] || !reg_wdata[MODE_BIT]);
    restart   = finish && !cfg_q[MODE_BIT];
    rate_now  = start ? reg_wdata[RATE_LSB +: 3] : cfg_q[RATE_LSB +: 3];
  end

  rate_decode #(
    .CLK_HZ   (CLK_HZ),
    .CNT_W    (CNT_W)
  ) u_rate (
    .rate_sel (rate_now),
    .period   (period)
  );

  ////////////////////////////////////////////////////////////////////////
  // pointer keeps its value until the host loads a new one
  function automatic logic [1:0] ptr_val_sel(input logic w, input logic [1:0] v,
                                             input logic [1:0] old);
    ptr_val_sel = w ? v : old;
  endfunction : ptr_val_sel

  // pointer and configuration; bit 15 is never stored, it is status
  always_comb begin
    ptr_d = ptr_val_sel(ptr_wr, ptr_val, ptr_q);
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = reg_wdata[14:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer; the period is fixed when a conversion starts
  always_comb begin
    busy_d   = busy_q;
    cnt_d    = cnt_q;
    done_d   = 1'b0;
    result_d = result_q;
    if (start) begin
      busy_d = 1'b1;
      cnt_d  = CNT_W'(period - 1'b1);
    end else if (finish) begin
      done_d   = 1'b1;
      result_d = sample_in;
      if (restart) begin
        cnt_d = CNT_W'(period - 1'b1);
      end else begin
        busy_d = 1'b0;
      end
    end else if (busy_q) begin
      cnt_d = CNT_W'(cnt_q - 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port answers one cycle after the strobe
  always_comb begin
    rd_valid_d = reg_rd;
    rd_data_d  = rd_data_q;
    if (reg_rd) begin
      unique case (ptr_q)
        PTR_RESULT: rd_data_d = result_q;
        PTR_CONFIG: rd_data_d = cfg_view(cfg_q, busy_q);
        default:    rd_data_d = 16'h0000;  // thresholds live elsewhere
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator queue; a result read or alert response clears a latched alert
  alert_queue u_alert (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .conv_done     (done_q),
    .beyond        (beyond_threshold),
    .cmp_queue_len (cfg_q[QUEUE_LSB +: 2]),
    .cmp_latch_en  (cfg_q[LATCH_BIT]),
    .alert_clear   (rd_result || alert_response),
    .alert_q       (alert_lvl)
  );

  // pin level follows polarity; queue off releases the pin
  always_comb begin
    alert_o_d  = cfg_q[POL_BIT] ? alert_lvl : ~alert_lvl;
    alert_oe_d = (cfg_q[QUEUE_LSB +: 2] != QUEUE_OFF);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; result starts at zero until the first finish
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q      <= PTR_RESET;
      cfg_q      <= CONFIG_RESET[14:0];
      result_q   <= RESULT_RESET;
      busy_q     <= 1'b0;
      cnt_q      <= '0;
      done_q     <= 1'b0;
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      alert_o_q  <= 1'b1;
      alert_oe_q <= 1'b0;
      seen_q     <= 1'b0;
    end else begin
      ptr_q      <= ptr_d;
      cfg_q      <= cfg_d;
      result_q   <= result_d;
      busy_q     <= busy_d;
      cnt_q      <= cnt_d;
      done_q     <= done_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      alert_o_q  <= alert_o_d;
      alert_oe_q <= alert_oe_d;
      seen_q     <= seen_q || done_d;
    end
  end

  // front-end controls straight from the configuration and sequencer flops
  always_comb begin
    input_pair_sel_q = cfg_q[PAIR_LSB +: 3];
    gain_range_sel_q = cfg_q[RANGE_LSB +: 3];
    converting_q     = busy_q;
    conv_done_q      = done_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks: conversion sequencer and result
  AST_RESULT_ON_DONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !$stable(result_q) |-> done_q)
    else $error("result changed without a finished conversion");

  AST_FINISH_DONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      finish |=> conv_done_q && result_q == $past(sample_in))
    else $error("finished conversion did not load the sample");

  AST_RESULT_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !seen_q |-> result_q == 16'h0000)
    else $error("result nonzero before first conversion");

  AST_START_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_wr && ptr_q == PTR_CONFIG && reg_wdata[STATUS_BIT] && !busy_q
      |=> busy_q && conv_done_q == 1'b0)
    else $error("start request while idle did not start");

  AST_IDLE_STAYS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !busy_q && !(reg_wr && ptr_q == PTR_CONFIG) |=> !busy_q)
    else $error("conversion started without a configuration write");

  AST_BUSY_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      busy_q && cnt_q != '0 |=> busy_q)
    else $error("conversion cut short by a write");

  AST_COUNT_DOWN: assert property (@(posedge ref_clk) disable iff (!reset_n)
      busy_q && cnt_q != '0 |=> cnt_q == CNT_W'($past(cnt_q) - 1'b1))
    else $error("conversion counter skipped a cycle");

  AST_START_CONT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_wr && ptr_q == PTR_CONFIG && !busy_q && !reg_wdata[MODE_BIT] |=> busy_q)
    else $error("continuous mode write did not start");

  // a new start one cycle after the end is legal, so the second cycle allows it
  AST_SINGLE_ENDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      finish && cfg_q[MODE_BIT] && !start |=> !busy_q ##1 (!busy_q || $past(start)))
    else $error("single-shot did not return to power-down");

  AST_CONT_RUNS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      finish && !cfg_q[MODE_BIT] |=> busy_q && conv_done_q)
    else $error("continuous mode stopped after a conversion");

  ////////////////////////////////////////////////////////////////////////
  // checks: pointer and register port
  AST_PTR_LOAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ptr_wr |=> ptr_q == $past(ptr_val))
    else $error("pointer write not taken");

  AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ptr_wr |=> $stable(ptr_q))
    else $error("pointer changed without a pointer write");

  AST_READ_RESULT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_rd && ptr_q == PTR_RESULT |=> rd_valid_q && rd_data_q == $past(result_q))
    else $error("result read returned wrong data");

  AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_rd && ptr_q[1] |=> rd_data_q == 16'h0000)
    else $error("unmapped read returned nonzero data");

  AST_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> rd_valid_q == $past(reg_rd))
    else $error("read valid does not follow the read strobe");

  AST_RDATA_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !reg_rd |=> $stable(rd_data_q))
    else $error("read data changed without a read");

  AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_wr && ptr_q == PTR_CONFIG
      |=> cfg_q == $past(reg_wdata[14:0]) ##1 1'b1)
    else $error("configuration write not stored");

  AST_CFG_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !(reg_wr && ptr_q == PTR_CONFIG) |=> $stable(cfg_q))
    else $error("configuration changed without a write");

  AST_READ_CFG_FIELDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_rd && ptr_q == PTR_CONFIG |=> rd_data_q[14:0] == $past(cfg_q))
    else $error("configuration read returned wrong fields");

  AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_rd && ptr_q == PTR_CONFIG |=> rd_data_q[STATUS_BIT] == !$past(busy_q))
    else $error("status bit does not mirror conversion state");

  ////////////////////////////////////////////////////////////////////////
  // checks: alert pin
  AST_PIN_RELEASE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cfg_q[QUEUE_LSB +: 2] == QUEUE_OFF |=> !alert_oe_q)
    else $error("alert pin driven with comparator off");

  AST_PIN_DRIVEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cfg_q[QUEUE_LSB +: 2] != QUEUE_OFF |=> alert_oe_q)
    else $error("alert pin released with comparator on");

  AST_POLARITY: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> alert_o_q ==
        ($past(cfg_q[POL_BIT]) ? $past(alert_lvl) : !$past(alert_lvl)))
    else $error("alert pin level ignores polarity");

endmodule : adc_result_and_config_regs

// ==== core/alert_queue.sv ====
/*
  Comparator queue and latch: counts successive out-of-threshold results
  and raises an internal alert level.  Assumes the threshold comparison
  itself is done outside and reported with each finished conversion.
*/
module alert_queue (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       conv_done,
  input  wire logic       beyond,
  input  wire logic [1:0] cmp_queue_len,
  input  wire logic       cmp_latch_en,
  input  wire logic       alert_clear,
  output logic            alert_q
);
  import adc_regs_pkg::*;

  logic [2:0] count_q, count_d;
  logic       alert_d;

  ////////////////////////////////////////////////////////////////////////
  // successive hits needed for each queue code
  function automatic logic [2:0] hits_needed(input logic [1:0] q);
    unique case (q)
      2'h0:    hits_needed = 3'h1;
      2'h1:    hits_needed = 3'h2;
      default: hits_needed = 3'h4;
    endcase
  endfunction : hits_needed

  // set beats clear so a hit in the clearing cycle survives
  always_comb begin
    count_d = count_q;
    alert_d = alert_q;
    if (alert_clear && cmp_latch_en) begin
      alert_d = 1'b0;
    end
    if (cmp_queue_len == QUEUE_OFF) begin
      count_d = 3'h0;
      alert_d = 1'b0;
    end else if (conv_done) begin
      if (beyond) begin
        if (count_q != 3'h4) begin
          count_d = count_q + 3'h1;
        end
        if (count_q + 3'h1 >= hits_needed(cmp_queue_len)) begin
          alert_d = 1'b1;
        end
      end else begin
        count_d = 3'h0;
        if (!cmp_latch_en) begin
          alert_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 3'h0;
      alert_q <= 1'b0;
    end else begin
      count_q <= count_d;
      alert_q <= alert_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a latched alert holds through in-range results until cleared
  AST_LATCH_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      alert_q && cmp_latch_en && !alert_clear && cmp_queue_len != QUEUE_OFF
      |=> alert_q)
    else $error("latched alert dropped without a clear");

endmodule : alert_queue

// ==== core/rate_decode.sv ====
/*
  Turns a sample-rate code into the number of reference clocks that one
  conversion lasts.  Assumes the caller loads the value only at the start
  of a conversion.
*/
module rate_decode #(
  parameter int CLK_HZ = adc_regs_pkg::REF_CLK_HZ,
  parameter int CNT_W  = 24
) (
  input  wire logic [2:0]       rate_sel,
  output logic      [CNT_W-1:0] period
);
  import adc_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // refuse a counter too narrow for the slowest rate
  if ((CLK_HZ / SPS_0) >= (64'd1 << CNT_W) || (CLK_HZ / SPS_7) < 1) begin : g_check
    $error("rate_decode: CNT_W too small or CLK_HZ too low");
  end

  // least time rounds down to whole cycles, never below one
  always_comb begin
    unique case (rate_sel)
      3'h0: period = CNT_W'(CLK_HZ / SPS_0);
      3'h1: period = CNT_W'(CLK_HZ / SPS_1);
      3'h2: period = CNT_W'(CLK_HZ / SPS_2);
      3'h3: period = CNT_W'(CLK_HZ / SPS_3);  // still in the doubling series, 64 per second
      3'h4: period = CNT_W'(CLK_HZ / SPS_4);
      3'h5: period = CNT_W'(CLK_HZ / SPS_5);
      3'h6: period = CNT_W'(CLK_HZ / SPS_6);
      3'h7: period = CNT_W'(CLK_HZ / SPS_7);
    endcase
  end

endmodule : rate_decode
